// ---- hw/rtcam_map.svh ----
/*
 * register offsets, field positions, the clock rate and timing counts
 * for the clock core; included by the core module, the checker and the bench
 */
`ifndef RTCAM_MAP_SVH
`define RTCAM_MAP_SVH

// byte offsets on the bus
`define RTCAM_CTRL_OFS 12'h000
`define RTCAM_OSC_OFS 12'h004
`define RTCAM_HOLD_OFS 12'h008
`define RTCAM_ALM0_OFS 12'h00C
`define RTCAM_ALM1_OFS 12'h010
`define RTCAM_ALM2_OFS 12'h014
`define RTCAM_STAT_OFS 12'h018

// control register fields
`define RTCAM_CTL_SNAP 0
`define RTCAM_CTL_LOAD 1
`define RTCAM_CTL_FAST 2
`define RTCAM_CTL_RUN 4
`define RTCAM_CTL_FAIL 5
`define RTCAM_CTL_MDET 6
`define RTCAM_CTL_OSCEN 7
`define RTCAM_CTL_AEN0 8
`define RTCAM_CTL_AEN1 9
`define RTCAM_CTL_AEN2 10
`define RTCAM_CTL_ACLR 11

// oscillator register fields
`define RTCAM_OSC_LFO 3
`define RTCAM_OSC_VALID 4
`define RTCAM_OSC_BIAS2 5
`define RTCAM_OSC_XMODE 6
`define RTCAM_OSC_AGC 7

// status register: alarm flags in bits 2:0
`define RTCAM_STAT_ALM 0

// timing, in microseconds, and the clock rate in MHz
`define RTCAM_CLK_MHZ 250
`define RTCAM_MISS_US 100
`define RTCAM_BLANK_US 2000
`define RTCAM_MISS_CYC (`RTCAM_MISS_US * `RTCAM_CLK_MHZ)
`define RTCAM_BLANK_CYC (`RTCAM_BLANK_US * `RTCAM_CLK_MHZ)

`endif

// ---- hw/rtcam_pkg.sv ----
/*
 * types for the clock core
 * assumes the map header is on the include path
 */
package rtcam_pkg;
   typedef enum logic [1:0] {
      RTCAM_XFER_IDLE = 2'b00,
      RTCAM_XFER_WAIT = 2'b01,
      RTCAM_XFER_DO = 2'b10
   } rtcam_xfer_t;

   typedef logic [31:0] rtcam_word_t;
endpackage

// ---- hw/rtcam_core.sv ----
/*
 * real-time clock core: 32-bit counter on oscillator ticks, holding
 * word with snapshot and preload, three alarm compares, auto-clear,
 * missing-oscillator detector and gated crystal-valid indicator,
 * all behind an ahb-lite slave.
 * assumes osc_level and xtal_amp_ok are synchronous to hclk and that
 * one master drives the bus with single word transfers.
 */
// Behaviour
// - flag failure when oscillator level stuck 100us
// - failure event offered for interrupt, wake, reset
// - crystal valid meaningless for 2ms after poweron
// - crystal valid forced low without bias doubling
// - writing one enables doubled oscillator bias
// - 32-bit counter increments per tick while running
// - counter wraps and keeps counting
// - auto-clear zeroes counter tick after alarm0 drops
// - only alarm0 drives the auto-clear
// - load and snapshot work while counter runs
// - load copies holding word, then clears request
// - snapshot copies counter to holding, clears request
// - fast mode transfers on system clock
// - slow mode waits for tick, needs run
// - alarm when counter equals compare value
// - alarm event offered for reset, wake, interrupt
// - disabling alarm enable clears its flag
// - re-enabled alarm recurs after full wrap
// - cleared run holds counter value
// - low-frequency source counts at bit one
`timescale 1ns/10ps
`include "rtcam_map.svh"

module rtcam_core #(
   parameter int unsigned MISS_CYC = `RTCAM_MISS_CYC,
   parameter int unsigned BLANK_CYC = `RTCAM_BLANK_CYC
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output rtcam_pkg::rtcam_word_t hrdata,
   // oscillator side
   input wire logic osc_level,
   input wire logic xtal_amp_ok,
   output logic osc_enable,
   output logic bias_double_en,
   output logic agc_enable,
   output logic xtal_mode,
   output logic lfo_select,
   // events to interrupt, wake and reset routing elsewhere
   output logic osc_fail_flag,
   output logic [2:0] alarm_event_flag,
   output rtcam_pkg::rtcam_word_t counter_value
);
   import rtcam_pkg::*;

   typedef struct packed {
      // bus data phase
      logic ph_wr;
      logic ph_rd;
      logic [11:0] ph_addr;
      logic [31:0] rdata;
      // control bits
      logic osc_en;
      logic mdet_en;
      logic fail;
      logic run;
      logic fast;
      logic load_req;
      logic snap_req;
      logic [2:0] aen;
      logic aclr;
      logic agc;
      logic xmode;
      logic bias2;
      logic lfo;
      // counter, holding word and compares
      logic [31:0] count;
      logic [31:0] hold;
      logic [31:0] alm0;
      logic [31:0] alm1;
      logic [31:0] alm2;
      // alarm events
      logic [2:0] alm_flag;
      logic alm0_prev;
      logic [2:0] match_q;
      // oscillator watch
      logic osc_prev;
      logic [31:0] stuck_cnt;
      logic [31:0] blank_cnt;
      rtcam_xfer_t xfer;
   } rtcam_state_t;

   rtcam_state_t st_r;
   rtcam_state_t st_nxt;

   logic tick;
   logic [2:0] match;
   logic [2:0] hit;
   logic amp_valid;
   logic blank_done;

   assign tick = st_r.osc_en && osc_level && !st_r.osc_prev;
   assign blank_done = st_r.blank_cnt >= BLANK_CYC;
   // blanking hides the indicator until the detector has settled
   assign amp_valid = st_r.bias2 && blank_done && xtal_amp_ok;

   // one compare per alarm; an event is the start of a match, so an
   // enable raised while the counter still sits on the compare value
   // waits for the next full wrap
   for (genvar g = 0; g < 3; g++) begin : g_alarm
      logic [31:0] cmp;
      if (g == 0) begin : g_sel0
         assign cmp = st_r.alm0;
      end else if (g == 1) begin : g_sel1
         assign cmp = st_r.alm1;
      end else begin : g_sel2
         assign cmp = st_r.alm2;
      end
      assign match[g] = st_r.count == cmp;
      assign hit[g] = st_r.aen[g] && match[g]
                      && !st_r.match_q[g];
   end

   function automatic logic [31:0] rd_mux(input logic [11:0] a,
                                          input rtcam_state_t s,
                                          input logic v);
      logic [31:0] r;
      r = 32'h00000000;
      unique case (a)
         `RTCAM_CTRL_OFS: begin
            r[`RTCAM_CTL_SNAP] = s.snap_req;
            r[`RTCAM_CTL_LOAD] = s.load_req;
            r[`RTCAM_CTL_FAST] = s.fast;
            r[`RTCAM_CTL_RUN] = s.run;
            r[`RTCAM_CTL_FAIL] = s.fail;
            r[`RTCAM_CTL_MDET] = s.mdet_en;
            r[`RTCAM_CTL_OSCEN] = s.osc_en;
            r[`RTCAM_CTL_AEN2:`RTCAM_CTL_AEN0] = s.aen;
            r[`RTCAM_CTL_ACLR] = s.aclr;
         end
         `RTCAM_OSC_OFS: begin
            r[`RTCAM_OSC_LFO] = s.lfo;
            r[`RTCAM_OSC_VALID] = v;
            r[`RTCAM_OSC_BIAS2] = s.bias2;
            r[`RTCAM_OSC_XMODE] = s.xmode;
            r[`RTCAM_OSC_AGC] = s.agc;
         end
         `RTCAM_HOLD_OFS: begin
            r = s.hold;
         end
         `RTCAM_ALM0_OFS: begin
            r = s.alm0;
         end
         `RTCAM_ALM1_OFS: begin
            r = s.alm1;
         end
         `RTCAM_ALM2_OFS: begin
            r = s.alm2;
         end
         `RTCAM_STAT_OFS: begin
            // flags read back here, cleared only through the enables
            r[2:0] = s.alm_flag;
         end
         default: r = 32'h00000000;
      endcase
      return r;
   endfunction

   always_comb begin
      logic take;
      logic [31:0] w;
      logic do_xfer;
      logic [2:0] aen_new;
      logic fail_set;
      take = 1'b0;
      w = hwdata;
      do_xfer = 1'b0;
      aen_new = 3'b000;
      fail_set = 1'b0;
      st_nxt = st_r;

      // bus: one address phase, zero wait data phase; hsize is not
      // decoded, so only whole-word transfers are meaningful
      take = hsel && hready && htrans[1];
      st_nxt.ph_wr = take && hwrite;
      st_nxt.ph_rd = take && !hwrite;
      st_nxt.ph_addr = {haddr[11:2], 2'b00};
      if (take && !hwrite) begin
         st_nxt.rdata = rd_mux({haddr[11:2], 2'b00}, st_r, amp_valid);
      end

      // oscillator edge seen on the synchronous level
      st_nxt.osc_prev = osc_level;

      // counter: two per tick from the low-frequency source
      if (tick && st_r.run) begin
         if (st_r.lfo) begin
            st_nxt.count = st_r.count + 32'h00000002;
         end else begin
            st_nxt.count = st_r.count + 32'h00000001;
         end
      end

      // alarm flags; only alarm0 arms the auto-clear
      st_nxt.match_q = match;
      for (int i = 0; i < 3; i++) begin
         if (hit[i]) begin
            st_nxt.alm_flag[i] = 1'b1;
         end
      end
      // a stopped counter must hold, so the clear only moves on ticks
      // that would also have counted
      if (tick && st_r.run) begin
         st_nxt.alm0_prev = match[0];
         // first tick after alarm0 has let go zeroes the counter
         if (st_r.aclr && st_r.alm0_prev && !match[0]) begin
            st_nxt.count = 32'h00000000;
         end
      end

      // missing oscillator: count system cycles at one level
      if (!st_r.mdet_en || osc_level != st_r.osc_prev) begin
         st_nxt.stuck_cnt = 32'h00000000;
      end else if (st_r.stuck_cnt < MISS_CYC) begin
         st_nxt.stuck_cnt = st_r.stuck_cnt + 32'h00000001;
      end else begin
         fail_set = 1'b1;
      end

      // blanking after oscillator power-on
      if (!st_r.osc_en) begin
         st_nxt.blank_cnt = 32'h00000000;
      end else if (!blank_done) begin
         st_nxt.blank_cnt = st_r.blank_cnt + 32'h00000001;
      end

      // transfers between holding word and counter
      unique case (st_r.xfer)
         RTCAM_XFER_IDLE: begin
            if (st_r.load_req || st_r.snap_req) begin
               st_nxt.xfer = st_r.fast ? RTCAM_XFER_DO :
                             RTCAM_XFER_WAIT;
            end
         end
         RTCAM_XFER_WAIT: begin
            // slow mode only finishes on a running tick
            if (tick && st_r.run) begin
               st_nxt.xfer = RTCAM_XFER_DO;
            end
         end
         RTCAM_XFER_DO: begin
            do_xfer = 1'b1;
            st_nxt.xfer = RTCAM_XFER_IDLE;
         end
      endcase
      if (do_xfer) begin
         if (st_r.load_req) begin
            st_nxt.count = st_r.hold;
            st_nxt.load_req = 1'b0;
         end else begin
            st_nxt.hold = st_r.count;
            st_nxt.snap_req = 1'b0;
         end
      end

      // register writes land in the data phase
      if (st_r.ph_wr) begin
         unique case (st_r.ph_addr)
            `RTCAM_CTRL_OFS: begin
               st_nxt.osc_en = w[`RTCAM_CTL_OSCEN];
               st_nxt.mdet_en = w[`RTCAM_CTL_MDET];
               if (!w[`RTCAM_CTL_FAIL]) begin
                  st_nxt.fail = 1'b0;
               end
               st_nxt.run = w[`RTCAM_CTL_RUN];
               st_nxt.fast = w[`RTCAM_CTL_FAST];
               // requests only set here; hardware clears them
               if (w[`RTCAM_CTL_LOAD] && st_r.xfer == RTCAM_XFER_IDLE) begin
                  st_nxt.load_req = 1'b1;
               end
               if (w[`RTCAM_CTL_SNAP] && st_r.xfer == RTCAM_XFER_IDLE
                   && !w[`RTCAM_CTL_LOAD]) begin
                  st_nxt.snap_req = 1'b1;
               end
               aen_new = w[`RTCAM_CTL_AEN2:`RTCAM_CTL_AEN0];
               st_nxt.aen = aen_new;
               for (int i = 0; i < 3; i++) begin
                  if (!aen_new[i]) begin
                     st_nxt.alm_flag[i] = 1'b0;
                  end
               end
               st_nxt.aclr = w[`RTCAM_CTL_ACLR];
            end
            `RTCAM_OSC_OFS: begin
               st_nxt.lfo = w[`RTCAM_OSC_LFO];
               st_nxt.bias2 = w[`RTCAM_OSC_BIAS2];
               st_nxt.xmode = w[`RTCAM_OSC_XMODE];
               st_nxt.agc = w[`RTCAM_OSC_AGC];
            end
            `RTCAM_HOLD_OFS: begin
               // a write here races a snapshot; software sequences them
               st_nxt.hold = w;
            end
            `RTCAM_ALM0_OFS: begin
               st_nxt.alm0 = w;
            end
            `RTCAM_ALM1_OFS: begin
               st_nxt.alm1 = w;
            end
            `RTCAM_ALM2_OFS: begin
               st_nxt.alm2 = w;
            end
            default: ;
         endcase
      end

      // a failure in the clearing cycle is kept
      if (fail_set) begin
         st_nxt.fail = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = st_r.rdata;
   assign osc_enable = st_r.osc_en;
   assign bias_double_en = st_r.bias2;
   assign agc_enable = st_r.agc;
   assign xtal_mode = st_r.xmode;
   assign lfo_select = st_r.lfo;
   assign osc_fail_flag = st_r.fail;
   assign alarm_event_flag = st_r.alm_flag;
   assign counter_value = st_r.count;
endmodule // rtcam_core

// ---- tb/rtcam_core_properties.sv ----
/* port checker for the clock core, bound into every rtcam_core.
 * assumes hready is tied to hreadyout and osc_level is hclk-synchronous */
`timescale 1ns/10ps
`include "rtcam_map.svh"
module rtcam_core_chk #(
   parameter int unsigned MISS_CYC = 20
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire rtcam_pkg::rtcam_word_t hrdata,
   // oscillator and events
   input wire logic osc_level,
   input wire logic bias_double_en,
   input wire logic agc_enable,
   input wire logic xtal_mode,
   input wire logic lfo_select,
   input wire logic osc_fail_flag,
   input wire logic [2:0] alarm_event_flag,
   input wire rtcam_pkg::rtcam_word_t counter_value
);
   import rtcam_pkg::*;
   logic wr_ctl_q, wr_osc_q, rd_osc_q, osc_q;
   logic [7:0] still, rec;
   wire taken = hsel & hready & htrans[1];
   wire [11:0] wa = {haddr[11:2], 2'h0};
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ctl_q <= 1'b0;
         wr_osc_q <= 1'b0;
         rd_osc_q <= 1'b0;
         osc_q <= 1'b0;
         still <= 8'h0;
         rec <= 8'hFF;
      end else begin
         wr_ctl_q <= taken & hwrite & (wa == `RTCAM_CTRL_OFS);
         wr_osc_q <= taken & hwrite & (wa == `RTCAM_OSC_OFS);
         rd_osc_q <= taken & !hwrite & (wa == `RTCAM_OSC_OFS);
         osc_q <= osc_level;
         // saturate so a long stall never wraps back below the limit
         still <= (osc_level != osc_q) ? 8'h0 :
            (still == 8'hFF) ? still : still + 8'h1;
         rec <= ((taken & hwrite) | (osc_level & !osc_q)) ? 8'h0 :
            (rec == 8'hFF) ? rec : rec + 8'h1;
      end
   end
   ready_high_a: assert property (hreadyout)
      else $error("wait state inserted");
   resp_okay_a: assert property (!hresp)
      else $error("error response");
   fail_after_stall_a: assert property ($rose(osc_fail_flag) |-> still >= MISS_CYC)
      else $error("fail flag without stall");
   valid_gated_a: assert property (rd_osc_q && !$past(wr_osc_q)
      && !$past(bias_double_en) && !$past(bias_double_en, 2)
      |-> !hrdata[`RTCAM_OSC_VALID])
      else $error("crystal valid without bias doubling");
   bias_follows_a: assert property (wr_osc_q |=>
      bias_double_en == $past(hwdata[`RTCAM_OSC_BIAS2]))
      else $error("bias doubling not written");
   osc_bits_a: assert property (wr_osc_q |=> {agc_enable, xtal_mode,
      lfo_select} == $past({hwdata[7], hwdata[6], hwdata[3]}))
      else $error("oscillator controls not written");
   counter_quiet_a: assert property ($changed(counter_value) |-> rec < 8'h8)
      else $error("counter moved without tick or write");
   alarm_clear_a: assert property (wr_ctl_q |=>
      (alarm_event_flag & ~$past(hwdata[10:8])) == 3'h0)
      else $error("alarm flag kept after disable");
   cover property ($rose(osc_fail_flag));
   cover property ($rose(alarm_event_flag[0]));
   cover property (counter_value == 32'h0 && $past(counter_value) == 32'hFFFFFFFF);
endmodule // rtcam_core_chk

bind rtcam_core rtcam_core_chk #(.MISS_CYC(MISS_CYC)) u_chk (.hclk, .hresetn,
   .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
   .hrdata, .osc_level, .bias_double_en, .agc_enable, .xtal_mode,
   .lfo_select, .osc_fail_flag, .alarm_event_flag, .counter_value);

// ---- tb/rtcam_osc_model.sv ----
/* oscillator model: square wave of a set half period in hclk cycles.
 * assumes run low models a stalled oscillator, holding its level */
`timescale 1ns/10ps
module rtcam_osc_model (
   // clock
   input wire logic hclk,
   // control
   input wire logic run,
   input wire logic [7:0] half,
   // output
   output logic osc_level
);
   logic [7:0] cnt;
   initial begin
      osc_level = 1'b0;
      cnt = 8'h0;
   end
   always @(posedge hclk) begin
      if (run && cnt + 8'h1 >= half) begin
         cnt <= 8'h0;
         osc_level <= !osc_level;
      end else if (run) begin
         cnt <= cnt + 8'h1;
      end
   end
endmodule // rtcam_osc_model

// ---- tb/rtcam_core_bench.sv ----
/* self-checking bench for the clock core over ahb-lite.
 * assumes the checker is bound and short sim counts 20 and 50 */
`timescale 1ns/10ps
`include "rtcam_map.svh"
module rtcam_core_bench;
   import rtcam_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic xtal_amp_ok = 1'b0, osc_run = 1'b1;
   logic [11:0] haddr = 12'h0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, osc_level, osc_enable, bias_double_en;
   logic agc_enable, xtal_mode, lfo_select, osc_fail_flag;
   logic [2:0] alarm_event_flag;
   rtcam_word_t hrdata, counter_value, q, e;
   int n_fail = 0, total_checks = 0, cyc = 0;
   initial forever #2 hclk = ~hclk;
   rtcam_core #(.MISS_CYC(20), .BLANK_CYC(50)) u_dut (.hclk, .hresetn,
      .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .osc_level,
      .xtal_amp_ok, .osc_enable, .bias_double_en, .agc_enable, .xtal_mode,
      .lfo_select, .osc_fail_flag, .alarm_event_flag, .counter_value);
   rtcam_osc_model u_osc (.hclk, .run(osc_run), .half(8'h8), .osc_level);
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test;
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one whole-word transfer; q holds read data afterwards
   task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task poll(input logic [31:0] m);
      for (int i = 0; i < 60; i++) begin
         ahb(1'b0, `RTCAM_CTRL_OFS, 32'h0);
         if ((q & m) == 32'h0) break;
      end
      chk(q & m, 32'h0);
   endtask
   task t_regs;
      ahb(1'b0, `RTCAM_CTRL_OFS, 32'h0);
      chk(q, 32'h0);
      ahb(1'b1, 12'h020, 32'hFFFFFFFF);
      ahb(1'b0, 12'h020, 32'h0);
      chk(q, 32'h0);
      ahb(1'b0, `RTCAM_OSC_OFS, 32'h0);
      chk(q, 32'h0);
      $display("test regs done");
   endtask
   task t_valid;
      ahb(1'b1, `RTCAM_CTRL_OFS, 32'h80);
      ahb(1'b1, `RTCAM_OSC_OFS, 32'h60);
      @(posedge hclk);
      chk(32'(bias_double_en), 32'h1);
      xtal_amp_ok <= 1'b1;
      ahb(1'b0, `RTCAM_OSC_OFS, 32'h0);
      chk(32'(q[4]), 32'h0);
      repeat (60) @(posedge hclk);
      ahb(1'b0, `RTCAM_OSC_OFS, 32'h0);
      chk(32'(q[4]), 32'h1);
      ahb(1'b1, `RTCAM_OSC_OFS, 32'h40);
      ahb(1'b0, `RTCAM_OSC_OFS, 32'h0);
      chk(32'(q[4]), 32'h0);
      $display("test valid done");
   endtask
   // load near the top while running, watch the wrap, snapshot slowly
   task t_count;
      ahb(1'b1, `RTCAM_HOLD_OFS, 32'hFFFFFFFE);
      ahb(1'b1, `RTCAM_CTRL_OFS, 32'h96);
      poll(32'h2);
      chk(32'(counter_value[31:1]), 32'h7FFFFFFF);
      for (int i = 0; i < 200 && counter_value !== 32'h1; i++) @(posedge hclk);
      chk(counter_value, 32'h1);
      ahb(1'b1, `RTCAM_CTRL_OFS, 32'h91);
      poll(32'h1);
      e = counter_value;
      ahb(1'b0, `RTCAM_HOLD_OFS, 32'h0);
      chk(32'(e - q <= 32'h2), 32'h1);
      ahb(1'b1, `RTCAM_CTRL_OFS, 32'h84);
      @(posedge hclk);
      e = counter_value;
      repeat (50) @(posedge hclk);
      chk(counter_value, e);
      $display("test count done");
   endtask
   task t_alarm(input logic [31:0] a0, input logic [31:0] a1,
      input logic [31:0] ctl);
      ahb(1'b1, `RTCAM_CTRL_OFS, 32'h84);
      ahb(1'b1, `RTCAM_HOLD_OFS, 32'h0);
      ahb(1'b1, `RTCAM_CTRL_OFS, 32'h86);
      poll(32'h2);
      ahb(1'b1, `RTCAM_ALM0_OFS, a0);
      ahb(1'b1, `RTCAM_ALM1_OFS, a1);
      ahb(1'b1, `RTCAM_CTRL_OFS, ctl);
   endtask
   task t_match;
      t_alarm(32'h5, 32'h3, 32'h394);
      for (int i = 0; i < 300 && alarm_event_flag[0] !== 1'b1; i++)
         @(posedge hclk);
      chk(counter_value, 32'h5);
      chk(32'(alarm_event_flag), 32'h3);
      ahb(1'b1, `RTCAM_CTRL_OFS, 32'h94);
      @(posedge hclk);
      chk(32'(alarm_event_flag), 32'h0);
      ahb(1'b1, `RTCAM_CTRL_OFS, 32'h394);
      repeat (100) @(posedge hclk);
      chk(32'(alarm_event_flag), 32'h0);
      $display("test alarm done");
   endtask
   // alarm1 sits below alarm0, so a clear at 3 would expose it
   task t_aclr;
      t_alarm(32'h6, 32'h2, 32'hB94);
      e = 32'h0;
      repeat (400) begin
         @(posedge hclk);
         if (counter_value > e) e = counter_value;
      end
      chk(e, 32'h7);
      $display("test autoclear done");
   endtask
   task t_lfo;
      ahb(1'b1, `RTCAM_OSC_OFS, 32'h8);
      t_alarm(32'h0, 32'h0, 32'h94);
      for (int i = 0; i < 100 && counter_value === 32'h0; i++) @(posedge hclk);
      chk(counter_value, 32'h2);
      ahb(1'b1, `RTCAM_OSC_OFS, 32'h0);
      $display("test lfo done");
   endtask
   task t_fail;
      ahb(1'b1, `RTCAM_CTRL_OFS, 32'hC0);
      repeat (100) @(posedge hclk);
      chk(32'(osc_fail_flag), 32'h0);
      ahb(1'b1, `RTCAM_CTRL_OFS, 32'h80);
      osc_run <= 1'b0;
      repeat (60) @(posedge hclk);
      chk(32'(osc_fail_flag), 32'h0);
      ahb(1'b1, `RTCAM_CTRL_OFS, 32'hC0);
      repeat (60) @(posedge hclk);
      chk(32'(osc_fail_flag), 32'h1);
      ahb(1'b1, `RTCAM_CTRL_OFS, 32'h80);
      osc_run <= 1'b1;
      ahb(1'b1, `RTCAM_CTRL_OFS, 32'h80);
      @(posedge hclk);
      chk(32'(osc_fail_flag), 32'h0);
      $display("test fail done");
   endtask
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_valid;
      t_count;
      t_match;
      t_aclr;
      t_lfo;
      t_fail;
      end_of_test;
   end
endmodule // rtcam_core_bench
